//--- dsf_driver_status.sv
// driver status flags: status word, bridge protection, event interrupt
// assumes measurement inputs synchronous to ref_clk, plain register port
//
// Behaviour
// - bit 31 shows standstill in every operating mode.
// - standstill asserts after 2^20 clocks without a new step pulse.
// - bit 30 reports open load on B, bit 29 on A.
// - open-load flags only inform; bridges are never touched by them.
// - short to ground sets bit 28 (B) or 27 (A), disables bridges.
// - ground-short flags hold until off time is 0 or enable pin inactive.
// - bit 26 is set while temperature exceeds the pre-warning threshold.
// - temperature limit sets bit 25; bridges off until pre-warning clears.
// - one pre-warning and one limit flag shared by both bridges.
// - bit 24 marks stall: load result zero or load-speed stall.
// - bits 20 to 16 show the actual current scaling value.
// - bit 15 set while driver runs in fullstep.
`timescale 1ns/1ps
`default_nettype none
module dsf_driver_status #(
    parameter int STANDSTILL_COUNT = dsf_pkg::STANDSTILL_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [dsf_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire logic step_pulse,
    input wire logic driver_enable_input_n,
    input wire dsf_pkg::dsf_sense_t sense,
    output logic bridge_enable,
    output logic irq
);
    dsf_pkg::dsf_flags_t flags;
    dsf_pkg::dsf_flags_t next_flags;
    logic [dsf_pkg::OFF_TIME_W-1:0] off_time_setting;
    logic [dsf_pkg::OFF_TIME_W-1:0] next_off_time_setting;
    logic [dsf_pkg::EVT_W-1:0] evt_status;
    logic [dsf_pkg::EVT_W-1:0] next_evt_status;
    logic [dsf_pkg::EVT_W-1:0] evt_mask;
    logic [dsf_pkg::EVT_W-1:0] next_evt_mask;
    logic [dsf_pkg::EVT_W-1:0] evt_set;
    logic [31:0] next_reg_rdata;
    logic [31:0] status_word;
    logic standstill;
    logic driver_off;
    logic bridge_block;
    logic next_bridge_block;
    logic [7:0] word_idx;

    // ------------------------------------------------------------
    // standstill detection
    // ------------------------------------------------------------
    // step timeout
    dsf_standstill_timer #(
        .COUNT_CYCLES(STANDSTILL_COUNT)
    ) u_standstill (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .step_pulse(step_pulse),
        .standstill(standstill)
    );

    // ------------------------------------------------------------
    // flag capture
    // ------------------------------------------------------------
    assign driver_off = (off_time_setting == '0) || driver_enable_input_n;

    always_comb begin
        next_flags = flags;
        next_flags.standstill = standstill;
        next_flags.open_load_b = sense.open_load_b;
        next_flags.open_load_a = sense.open_load_a;
        if (driver_off) begin
            next_flags.ground_short_phase_b = 1'b0;
            next_flags.ground_short_phase_a = 1'b0;
        end else begin
            if (sense.ground_short_b) begin
                next_flags.ground_short_phase_b = 1'b1;
            end
            if (sense.ground_short_a) begin
                next_flags.ground_short_phase_a = 1'b1;
            end
        end
        next_flags.temp_prewarn = sense.temp_prewarn;
        if (sense.temp_limit) begin
            next_flags.temp_limit_flag = 1'b1;
        end else if (!sense.temp_prewarn) begin
            next_flags.temp_limit_flag = 1'b0;
        end
        next_flags.stall_flag = (sense.load_measure_result == '0) || sense.load_speed_stall;
        next_flags.current_scale = sense.current_scale;
        next_flags.fullstep_active = sense.fullstep_active;
    end

    // ------------------------------------------------------------
    // bridge protection
    // ------------------------------------------------------------
    always_comb begin
        // one temp flag for both bridges
        next_bridge_block = next_flags.ground_short_phase_b || next_flags.ground_short_phase_a
            || next_flags.temp_limit_flag;
    end

    assign bridge_enable = !driver_off && !bridge_block;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            flags <= '0;
            bridge_block <= 1'b0;
        end else begin
            flags <= next_flags;
            bridge_block <= next_bridge_block;
        end
    end

    // ------------------------------------------------------------
    // status word assembly
    // ------------------------------------------------------------
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[dsf_pkg::POS_STANDSTILL] = flags.standstill;
        status_word[dsf_pkg::POS_OPEN_LOAD_B] = flags.open_load_b;
        status_word[dsf_pkg::POS_OPEN_LOAD_A] = flags.open_load_a;
        status_word[dsf_pkg::POS_GROUND_SHORT_B] = flags.ground_short_phase_b;
        status_word[dsf_pkg::POS_GROUND_SHORT_A] = flags.ground_short_phase_a;
        status_word[dsf_pkg::POS_TEMP_PREWARN] = flags.temp_prewarn;
        status_word[dsf_pkg::POS_TEMP_LIMIT] = flags.temp_limit_flag;
        status_word[dsf_pkg::POS_STALL] = flags.stall_flag;
        status_word[dsf_pkg::POS_CURRENT_LSB +: dsf_pkg::CURRENT_W] = flags.current_scale;
        status_word[dsf_pkg::POS_FULLSTEP] = flags.fullstep_active;
    end

    // ------------------------------------------------------------
    // events and interrupt
    // ------------------------------------------------------------
    always_comb begin
        evt_set = '0;
        evt_set[dsf_pkg::EVT_STANDSTILL] = next_flags.standstill && !flags.standstill;
        evt_set[dsf_pkg::EVT_GROUND_SHORT] =
            (next_flags.ground_short_phase_b && !flags.ground_short_phase_b)
            || (next_flags.ground_short_phase_a && !flags.ground_short_phase_a);
        evt_set[dsf_pkg::EVT_TEMP_PREWARN] = next_flags.temp_prewarn && !flags.temp_prewarn;
        evt_set[dsf_pkg::EVT_TEMP_LIMIT] = next_flags.temp_limit_flag && !flags.temp_limit_flag;
        evt_set[dsf_pkg::EVT_STALL] = next_flags.stall_flag && !flags.stall_flag;
    end

    assign irq = |(evt_status & evt_mask);

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    assign word_idx = reg_addr[dsf_pkg::ADDR_W-1:2];

    always_comb begin
        next_off_time_setting = off_time_setting;
        next_evt_mask = evt_mask;
        next_evt_status = evt_status;
        next_reg_rdata = 32'h0000_0000;
        if (reg_write) begin
            if (word_idx == dsf_pkg::IDX_DRIVER_CONTROL) begin
                next_off_time_setting = reg_wdata[dsf_pkg::OFF_TIME_W-1:0];
            end else if (word_idx == dsf_pkg::IDX_EVENT_STATUS) begin
                next_evt_status = evt_status & ~reg_wdata[dsf_pkg::EVT_W-1:0];
            end else if (word_idx == dsf_pkg::IDX_EVENT_MASK) begin
                next_evt_mask = reg_wdata[dsf_pkg::EVT_W-1:0];
            end
        end
        next_evt_status = next_evt_status | evt_set;
        if (reg_read) begin
            if (word_idx == dsf_pkg::IDX_DRIVER_STATUS_WORD) begin
                next_reg_rdata = status_word;
            end else if (word_idx == dsf_pkg::IDX_DRIVER_CONTROL) begin
                next_reg_rdata[dsf_pkg::OFF_TIME_W-1:0] = off_time_setting;
            end else if (word_idx == dsf_pkg::IDX_EVENT_STATUS) begin
                next_reg_rdata[dsf_pkg::EVT_W-1:0] = evt_status;
            end else if (word_idx == dsf_pkg::IDX_EVENT_MASK) begin
                next_reg_rdata[dsf_pkg::EVT_W-1:0] = evt_mask;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            off_time_setting <= dsf_pkg::OFF_TIME_RESET;
            evt_mask <= dsf_pkg::EVT_MASK_RESET;
            evt_status <= '0;
            reg_rdata <= 32'h0000_0000;
        end else begin
            off_time_setting <= next_off_time_setting;
            evt_mask <= next_evt_mask;
            evt_status <= next_evt_status;
            reg_rdata <= next_reg_rdata;
        end
    end
endmodule
`default_nettype wire

//--- dsf_pkg.sv
// package of constants and carrier types for the driver status flags block
// assumes a single 10 MHz device clock and a word-indexed register port
package dsf_pkg;

    // ------------------------------------------------------------
    // clocking and counts
    // ------------------------------------------------------------
    localparam int CLK_HZ = 10000000;
    localparam int STANDSTILL_CYCLES = 1048576;

    // ------------------------------------------------------------
    // register indices, byte address is four times the index
    // ------------------------------------------------------------
    localparam int ADDR_W = 10;
    localparam logic [7:0] IDX_DRIVER_STATUS_WORD = 8'h6f;
    localparam logic [7:0] IDX_DRIVER_CONTROL = 8'h70;
    localparam logic [7:0] IDX_EVENT_STATUS = 8'h71;
    localparam logic [7:0] IDX_EVENT_MASK = 8'h72;

    // ------------------------------------------------------------
    // status word field positions
    // ------------------------------------------------------------
    localparam int POS_STANDSTILL = 31;
    localparam int POS_OPEN_LOAD_B = 30;
    localparam int POS_OPEN_LOAD_A = 29;
    localparam int POS_GROUND_SHORT_B = 28;
    localparam int POS_GROUND_SHORT_A = 27;
    localparam int POS_TEMP_PREWARN = 26;
    localparam int POS_TEMP_LIMIT = 25;
    localparam int POS_STALL = 24;
    localparam int POS_CURRENT_LSB = 16;
    localparam int POS_FULLSTEP = 15;
    localparam int CURRENT_W = 5;
    localparam int LOAD_W = 10;

    // ------------------------------------------------------------
    // control register fields and reset values
    // ------------------------------------------------------------
    localparam int OFF_TIME_W = 4;
    localparam logic [3:0] OFF_TIME_RESET = 4'h0;

    // ------------------------------------------------------------
    // event bits, same layout in status and mask
    // ------------------------------------------------------------
    localparam int EVT_W = 5;
    localparam int EVT_STANDSTILL = 0;
    localparam int EVT_GROUND_SHORT = 1;
    localparam int EVT_TEMP_PREWARN = 2;
    localparam int EVT_TEMP_LIMIT = 3;
    localparam int EVT_STALL = 4;
    localparam logic [4:0] EVT_MASK_RESET = 5'h00;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic open_load_b;
        logic open_load_a;
        logic ground_short_b;
        logic ground_short_a;
        logic temp_prewarn;
        logic temp_limit;
        logic load_speed_stall;
        logic [9:0] load_measure_result;
        logic [4:0] current_scale;
        logic fullstep_active;
    } dsf_sense_t;

    typedef struct packed {
        logic standstill;
        logic open_load_b;
        logic open_load_a;
        logic ground_short_phase_b;
        logic ground_short_phase_a;
        logic temp_prewarn;
        logic temp_limit_flag;
        logic stall_flag;
        logic [4:0] current_scale;
        logic fullstep_active;
    } dsf_flags_t;

endpackage

//--- dsf_standstill_timer.sv
// standstill timer: counts device clocks since the latest step pulse
// assumes step pulses are one clock long and synchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module dsf_standstill_timer #(
    parameter int COUNT_CYCLES = dsf_pkg::STANDSTILL_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic step_pulse,
    output logic standstill
);
    localparam int CNT_W = $clog2(COUNT_CYCLES + 1);
    localparam logic [CNT_W-1:0] LIMIT = CNT_W'(COUNT_CYCLES);

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic next_standstill;

    // ------------------------------------------------------------
    // saturating count
    // ------------------------------------------------------------
    always_comb begin
        next_count = count;
        next_standstill = standstill;
        if (step_pulse) begin
            next_count = '0;
            next_standstill = 1'b0;
        end else if (count != LIMIT) begin
            next_count = count + CNT_W'(1);
            next_standstill = (count + CNT_W'(1)) == LIMIT;
        end else begin
            next_standstill = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= '0;
            standstill <= 1'b0;
        end else begin
            count <= next_count;
            standstill <= next_standstill;
        end
    end
endmodule
`default_nettype wire

//--- dsf_driver_status_properties.sv
// assertions on the driver status flags block ports
// assumes binding onto dsf_driver_status, one clock domain
`timescale 1ns/1ps
`default_nettype none
module dsf_driver_status_properties #(
    parameter int STANDSTILL_COUNT = dsf_pkg::STANDSTILL_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [dsf_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic step_pulse,
    input wire logic driver_enable_input_n,
    input wire dsf_pkg::dsf_sense_t sense,
    input wire logic bridge_enable,
    input wire logic irq
);
    // ------------------------------------------------------------
    // status reads and bridge protection
    // ------------------------------------------------------------
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    logic st_rd;
    assign st_rd = reg_read && (reg_addr[9:2] == dsf_pkg::IDX_DRIVER_STATUS_WORD);
    property p_rd_idle;
        !reg_read |=> reg_rdata == 32'h0000_0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_reserved;
        st_rd |=> reg_rdata[23:21] == 3'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits set");
    property p_standstill;
        st_rd && $past(step_pulse, 2) |=> !reg_rdata[31];
    endproperty
    a_standstill: assert property (p_standstill) else $error("early standstill");
    property p_levels;
        st_rd |=> {reg_rdata[30:29], reg_rdata[26], reg_rdata[15]} == $past({sense.open_load_b,
            sense.open_load_a, sense.temp_prewarn, sense.fullstep_active}, 2);
    endproperty
    a_levels: assert property (p_levels) else $error("levels wrong");
    property p_stall;
        st_rd |=> reg_rdata[24] == ($past(sense.load_measure_result, 2) == 10'h000
            || $past(sense.load_speed_stall, 2));
    endproperty
    a_stall: assert property (p_stall) else $error("stall bit wrong");
    property p_current;
        st_rd |=> reg_rdata[20:16] == $past(sense.current_scale, 2);
    endproperty
    a_current: assert property (p_current) else $error("current scale wrong");
    property p_fault_off;
        sense.ground_short_b || sense.ground_short_a || sense.temp_limit |=> !bridge_enable;
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("bridge on in fault");
    property p_limit_hold;
        sense.temp_limit ##1 sense.temp_prewarn |=> !bridge_enable;
    endproperty
    a_limit_hold: assert property (p_limit_hold) else $error("bridge on while hot");
    property p_pin_off;
        driver_enable_input_n |-> !bridge_enable;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("bridge on, pin off");
    c_status_read: cover property (st_rd);
    c_bridge_cut: cover property ($fell(bridge_enable));
    c_irq: cover property ($rose(irq));
endmodule

bind dsf_driver_status dsf_driver_status_properties #(
    .STANDSTILL_COUNT(STANDSTILL_COUNT)
) u_properties (
    .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .step_pulse(step_pulse), .driver_enable_input_n(driver_enable_input_n),
    .sense(sense), .bridge_enable(bridge_enable), .irq(irq)
);
`default_nettype wire

//--- dsf_driver_status_test.sv
// self-checking bench for the driver status flags block
// assumes dsf_pkg, the design and its checker compiled first
`timescale 1ns/1ps
`default_nettype none
module dsf_driver_status_test;
    localparam int SC = 16;
    localparam logic [7:0] ST = dsf_pkg::IDX_DRIVER_STATUS_WORD;
    localparam logic [7:0] CT = dsf_pkg::IDX_DRIVER_CONTROL;
    localparam logic [7:0] EV = dsf_pkg::IDX_EVENT_STATUS;
    localparam logic [7:0] MK = dsf_pkg::IDX_EVENT_MASK;
    logic ref_clk, rst_b, reg_write, reg_read, step_pulse, driver_enable_input_n;
    logic bridge_enable, irq;
    logic [9:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    dsf_pkg::dsf_sense_t sense;
    int n_mismatch, n_checks;

    dsf_driver_status #(.STANDSTILL_COUNT(SC)) u_dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .step_pulse(step_pulse), .driver_enable_input_n(driver_enable_input_n),
        .sense(sense), .bridge_enable(bridge_enable), .irq(irq)
    );

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        @(posedge ref_clk);
        reg_write <= 1'b1;
        reg_addr <= {idx, 2'b00};
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_write <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] m, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_read <= 1'b1;
        reg_addr <= {idx, 2'b00};
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1;
        chk(reg_rdata & m, exp);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge ref_clk);
        n_mismatch++;
        test_done();
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        n_mismatch = 0;
        n_checks = 0;
        {rst_b, reg_write, reg_read, step_pulse, driver_enable_input_n} = 5'h00;
        reg_addr = 10'h000;
        reg_wdata = 32'h0000_0000;
        sense = '0;
        sense.load_measure_result = 10'h3ff;
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        chk({31'h0, bridge_enable}, 32'h0000_0000);
        rd(CT, 32'hffff_ffff, 32'h0000_0000);
        rd(MK, 32'hffff_ffff, 32'h0000_0000);
        rd(8'h7f, 32'hffff_ffff, 32'h0000_0000);
        @(posedge ref_clk);
        step_pulse <= 1'b1;
        @(posedge ref_clk);
        step_pulse <= 1'b0;
        repeat (SC - 2) @(posedge ref_clk);
        rd(ST, 32'h8000_0000, 32'h0000_0000);
        rd(ST, 32'h8000_0000, 32'h8000_0000);
        @(posedge ref_clk);
        step_pulse <= 1'b1;
        @(posedge ref_clk);
        step_pulse <= 1'b0;
        rd(ST, 32'h8000_0000, 32'h0000_0000);
        wr(CT, 32'h0000_0003);
        chk({31'h0, bridge_enable}, 32'h0000_0001);
        wr(ST, 32'hffff_ffff);
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            sense.open_load_b <= i[0];
            sense.open_load_a <= i[1];
            sense.temp_prewarn <= i[0];
            sense.fullstep_active <= i[1];
            sense.current_scale <= 5'(i * 9 + 4);
            sense.load_measure_result <= (i == 2) ? 10'h000 : 10'h3ff;
            sense.load_speed_stall <= (i == 3);
            rd(ST, 32'h7fff_ffff, {1'b0, i[0], i[1], 2'b00, i[0], 1'b0, i >= 2, 3'b000,
                5'(i * 9 + 4), i[1], 15'h0000});
            chk({31'h0, bridge_enable}, 32'h0000_0001);
        end
        @(posedge ref_clk);
        sense.temp_prewarn <= 1'b0;
        wr(EV, 32'h0000_001f);
        wr(MK, 32'h0000_0002);
        @(posedge ref_clk);
        sense.ground_short_b <= 1'b1;
        @(posedge ref_clk);
        sense.ground_short_b <= 1'b0;
        #1;
        chk({30'h0, bridge_enable, irq}, 32'h0000_0001);
        rd(ST, 32'h1800_0000, 32'h1000_0000);
        wr(EV, 32'h0000_0002);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(CT, 32'h0000_0000);
        wr(CT, 32'h0000_0003);
        rd(ST, 32'h1800_0000, 32'h0000_0000);
        chk({31'h0, bridge_enable}, 32'h0000_0001);
        wr(MK, 32'h0000_0000);
        @(posedge ref_clk);
        sense.ground_short_a <= 1'b1;
        @(posedge ref_clk);
        sense.ground_short_a <= 1'b0;
        rd(ST, 32'h1800_0000, 32'h0800_0000);
        chk({30'h0, bridge_enable, irq}, 32'h0000_0000);
        rd(EV, 32'h0000_0002, 32'h0000_0002);
        @(posedge ref_clk);
        driver_enable_input_n <= 1'b1;
        @(posedge ref_clk);
        driver_enable_input_n <= 1'b0;
        rd(ST, 32'h1800_0000, 32'h0000_0000);
        chk({31'h0, bridge_enable}, 32'h0000_0001);
        @(posedge ref_clk);
        sense.temp_prewarn <= 1'b1;
        sense.temp_limit <= 1'b1;
        @(posedge ref_clk);
        sense.temp_limit <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rd(ST, 32'h1e00_0000, 32'h0600_0000);
        chk({31'h0, bridge_enable}, 32'h0000_0000);
        @(posedge ref_clk);
        sense.temp_prewarn <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk({31'h0, bridge_enable}, 32'h0000_0001);
        rd(ST, 32'h0600_0000, 32'h0000_0000);
        test_done();
    end
endmodule
`default_nettype wire
